/* rtl/exc_pkg.sv */
// shared constants and types of the interruption and exception unit
package exc_pkg;
    // preferred-storage locations (byte addresses)
    localparam logic [11:0] EXT_OLD = 12'h018;
    localparam logic [11:0] SVC_OLD = 12'h020;
    localparam logic [11:0] PGM_OLD = 12'h028;
    localparam logic [11:0] TMR_LOC = 12'h050;
    localparam logic [11:0] EXT_NEW = 12'h058;
    localparam logic [11:0] SVC_NEW = 12'h060;
    localparam logic [11:0] PGM_NEW = 12'h068;
    // index into the 12-bit code that stands for interruption-code bits 20-31
    localparam int CB_TIMER = 7;
    localparam int CB_SWITCH = 6;
    localparam int CB_SIG_LO = 2;
    localparam int CB_PROC = 1;
    localparam int CB_ABN = 0;
    localparam int N_SIG = 4;
    localparam int N_SRC = 4;
    // one at bit 21 plus one at bit 23 of a word numbered from the left
    localparam logic [31:0] TMR_DEC = 32'h0000_0500;
    // instruction-length codes
    localparam logic [1:0] ILC_1 = 2'h1;
    localparam logic [1:0] ILC_2 = 2'h2;
    localparam logic [1:0] ILC_3 = 2'h3;
    // program interruption codes
    localparam logic [7:0] IC_DATA = 8'h07;
    localparam logic [7:0] IC_FXO = 8'h08;
    localparam logic [7:0] IC_FXDIV = 8'h09;
    localparam logic [7:0] IC_DCO = 8'h0A;
    localparam logic [7:0] IC_DCDIV = 8'h0B;
    localparam logic [7:0] IC_EXO = 8'h0C;
    localparam logic [7:0] IC_EXU = 8'h0D;
    localparam logic [7:0] IC_SIG = 8'h0E;
    localparam logic [7:0] IC_FPDIV = 8'h0F;
    localparam logic [7:0] IC_LOCK = 8'h10;
    localparam logic [7:0] IC_STOP = 8'h11;
    // computing element states
    localparam logic [1:0] ST_ZERO = 2'h0;
    localparam logic [1:0] ST_ONE = 2'h1;
    localparam logic [1:0] ST_TWO = 2'h2;
    localparam logic [1:0] ST_THREE = 2'h3;
    // register offsets
    localparam logic [7:0] OFF_MASK = 8'h00;
    localparam logic [7:0] OFF_TIMER = 8'h04;
    localparam logic [7:0] OFF_PEND = 8'h08;
    localparam logic [7:0] OFF_ABN = 8'h0C;
    localparam logic [7:0] OFF_ABNMASK = 8'h10;
    localparam logic [7:0] OFF_PROC = 8'h14;
    localparam logic [7:0] OFF_CONFIG = 8'h18;
    localparam logic [7:0] OFF_LAST = 8'h1C;

    typedef enum logic [2:0] {
        ACT_COMPLETE = 3'h1,
        ACT_SUPPRESS = 3'h2,
        ACT_TERMINATE = 3'h4
    } act_type;
    typedef enum logic [3:0] {
        FIX_NONE = 4'h1,
        FIX_ZERO = 4'h2,
        FIX_UP128 = 4'h4,
        FIX_DN128 = 4'h8
    } fix_type;
    // status-word bit 7 and program mask bits 36-39
    typedef struct packed {
        logic sys7;
        logic fxo;
        logic dco;
        logic exu;
        logic sig;
    } mask_type;
    typedef struct packed {
        logic data;
        logic fxo;
        logic fxdiv;
        logic cvb;
        logic dco;
        logic dcdiv;
        logic exo;
        logic exu;
        logic sig;
        logic fpdiv;
        logic lock;
        logic stop;
    } cause_type;
    typedef struct packed {
        logic [N_SRC-1:0] elc_cfg;
        logic test_sw;
        logic [1:0] ce_state;
    } cfg_type;
    typedef struct packed {
        logic valid;
        cause_type cause;
        logic [1:0] ilc;
        logic io_instr;
        logic ifetch;
        logic svc;
        logic [7:0] svc_imm;
        logic via_exec;
        logic boundary;
        logic exit_pt;
    } pipe_event_type;
    typedef struct packed {
        logic valid;
        logic [11:0] old_a;
        logic [11:0] new_a;
        logic [11:0] code;
        logic [1:0] ilc;
        act_type act;
    } switch_type;
    typedef struct packed {
        logic valid;
        act_type act;
        fix_type fix;
    } result_type;
endpackage : exc_pkg

/* rtl/interruption_and_exception_unit.sv */
// program, supervisor-call and external interruption logic with the timer
//
// Summary of operation
// - program exception: old word 40, new 104
// - bad decimal data terminates, length 2/3
// - fixed overflow completes, masked by bit 36
// - decimal overflow completes, mask 37, length 3
// - decimal divide suppresses, length code 3
// - exponent overflow: characteristic stored 128 lower
// - underflow: true zero, or 128 higher
// - zero-fraction significance, mask bit 39 decides
// - floating divide by zero fraction suppresses
// - i/o lockout terminates i/o instruction only
// - stopped storage: fetch suppressed, data terminated
// - supervisor call: old word 32, new 96
// - call byte into code; length 1 or 2
// - external requests held, merged, presented together
// - external taken with mask 7 at boundary
// - element check bypasses mask in certain states
// - external: old word 24, new 88
// - timer decremented at bits 21 and 23
// - timer crossing to negative requests bit 24
// - timer holds when stopped or stepping
// - long instructions terminate at next exit point
// - panel switch requests bit 25 per state
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
module interruption_and_exception_unit (
    input logic pclk, // clock, 40 MHz
    input logic presetn, // async reset
    input logic psel, // apb select
    input logic penable, // apb access phase
    input logic pwrite, // apb write
    input logic [7:0] paddr, // apb byte address
    input logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input exc_pkg::pipe_event_type ev, // pipeline events
    input logic mains_tick, // mains-derived timer tick pin
    input logic panel_sw, // panel interrupt switch pin
    input logic interlock_sw, // panel interlock switch pin
    input logic rate_step, // rate switch on instruction step
    input logic stopped, // element in stopped state
    input logic timer_dis_sw, // disable-timer switch
    input logic [exc_pkg::N_SIG-1:0] ext_sig, // direct-control signals
    input logic [exc_pkg::N_SRC-1:0] elc_req, // element_check requests
    input logic [exc_pkg::N_SRC-1:0] proc_req, // processor requests
    output exc_pkg::switch_type psw_switch, // status switch request
    output exc_pkg::result_type result // completion control
);
    import exc_pkg::*;

    localparam int NPIN = 6 + N_SIG + 2 * N_SRC;

    typedef struct packed {
        mask_type msk;
        logic [31:0] tmr;
        logic [11:0] pend;
        logic [N_SRC-1:0] acr;
        logic [N_SRC-1:0] acrm;
        logic [N_SRC-1:0] prr;
        cfg_type cfg;
        logic tick_q;
        logic sw_q;
        logic [N_SIG-1:0] sig_q;
        switch_type sw;
        result_type res;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } unit_state_type;

    unit_state_type st;
    unit_state_type next_st;

    logic [NPIN-1:0] pins;
    logic s_tick;
    logic s_sw;
    logic s_ilk;
    logic s_step;
    logic s_stop;
    logic s_tdis;
    logic [N_SIG-1:0] s_sig;
    logic [N_SRC-1:0] s_elc;
    logic [N_SRC-1:0] s_proc;

    pin_sync #(
        .W(NPIN)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({mains_tick, panel_sw, interlock_sw, rate_step, stopped, timer_dis_sw,
              ext_sig, elc_req, proc_req}),
        .dout(pins)
    );
    assign {s_tick, s_sw, s_ilk, s_step, s_stop, s_tdis, s_sig, s_elc, s_proc} = pins;

    logic enc_take;
    logic [7:0] enc_code;
    logic [1:0] enc_ilc;
    act_type enc_act;
    fix_type enc_fix;

    prog_exc_encoder u_enc (
        .cause(ev.cause),
        .msk(st.msk),
        .ilc_in(ev.ilc),
        .io_instr(ev.io_instr),
        .ifetch(ev.ifetch),
        .take(enc_take),
        .code(enc_code),
        .ilc(enc_ilc),
        .act(enc_act),
        .fix(enc_fix)
    );

    // bus decode
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic tmr_wr;
    logic [N_SRC-1:0] acr_clr;
    logic [N_SRC-1:0] prr_clr;

    assign setup = psel & ~penable;
    assign wr = psel & penable & st.pready & pwrite & hit;
    assign tmr_wr = wr & (paddr == OFF_TIMER);
    assign acr_clr = (wr && paddr == OFF_ABN) ? pwdata[N_SRC-1:0] : '0;
    assign prr_clr = (wr && paddr == OFF_PROC) ? pwdata[N_SRC-1:0] : '0;

    always_comb begin
        hit = 1'b1;
        rd = '0;
        case (paddr)
            OFF_MASK: rd[$bits(mask_type)-1:0] = st.msk;
            OFF_TIMER: rd = st.tmr;
            OFF_PEND: rd[11:0] = st.pend;
            OFF_ABN: rd[N_SRC-1:0] = st.acr;
            OFF_ABNMASK: rd[N_SRC-1:0] = st.acrm;
            OFF_PROC: rd[N_SRC-1:0] = st.prr;
            OFF_CONFIG: rd[$bits(cfg_type)-1:0] = st.cfg;
            OFF_LAST: rd[16:0] = {st.sw.act, st.sw.ilc, st.sw.code};
            default: hit = 1'b0;
        endcase
    end

    // event detection and conditions
    logic tick_e;
    logic sw_e;
    logic [N_SIG-1:0] sig_e;
    logic hold;
    logic sw_ok;
    logic elc_byp;
    logic [11:0] ext_code;
    logic at_exit;
    logic pgm_take;
    logic svc_take;
    logic ext_take;
    logic [31:0] tmr_dec;

    assign tick_e = s_tick & ~st.tick_q;
    assign sw_e = s_sw & ~st.sw_q;
    assign sig_e = s_sig & ~st.sig_q;
    assign hold = s_stop | s_step | (st.cfg.ce_state == ST_ZERO && s_tdis);
    assign tmr_dec = st.tmr - TMR_DEC;

    // state Two or Three listens to the switch only with the interlock on
    assign sw_ok = (st.cfg.ce_state == ST_ZERO) || (st.cfg.ce_state == ST_ONE) || s_ilk;

    // element check from a configured element ignores the system mask in states One and Two, and in Zero with the test switch off
    assign elc_byp = (|(st.acr & st.cfg.elc_cfg))
                     && ((st.cfg.ce_state == ST_ZERO && !st.cfg.test_sw)
                         || st.cfg.ce_state == ST_ONE
                         || st.cfg.ce_state == ST_TWO);

    always_comb begin
        ext_code = st.pend;
        ext_code[CB_PROC] = |st.prr;
        ext_code[CB_ABN] = (|(st.acr & st.acrm)) | elc_byp;
    end

    // long instructions offer exit points where they can be cut short
    assign at_exit = ev.boundary | ev.exit_pt;
    assign pgm_take = ev.valid & enc_take;
    assign svc_take = ev.valid & ev.svc & ~enc_take;
    assign ext_take = at_exit & ~pgm_take & ~svc_take
                      & ((st.msk.sys7 & (|ext_code)) | elc_byp);

    always_comb begin
        next_st = st;
        next_st.sw.valid = 1'b0;
        next_st.res.valid = 1'b0;
        next_st.tick_q = s_tick;
        next_st.sw_q = s_sw;
        next_st.sig_q = s_sig;
        // bus answers one cycle after setup
        next_st.pready = setup;
        next_st.pslverr = setup & ~hit;
        if (setup) begin
            next_st.prdata = hit ? rd : '0;
        end

        // one-shot requests are cleared when taken; fresh events below win
        if (ext_take) begin
            next_st.pend = '0;
            if (elc_byp) begin
                next_st.cfg.ce_state = ST_THREE;
            end
        end
        if (tick_e && !hold) begin
            next_st.tmr = tmr_dec;
            // large negative to large positive is not a crossing
            if (!st.tmr[31] && tmr_dec[31]) begin
                next_st.pend[CB_TIMER] = 1'b1;
            end
        end
        if (sw_e && sw_ok) begin
            next_st.pend[CB_SWITCH] = 1'b1;
        end
        next_st.pend[CB_SIG_LO +: N_SIG] = next_st.pend[CB_SIG_LO +: N_SIG] | sig_e;
        // held requests persist until software resets them
        next_st.acr = (st.acr & ~acr_clr) | s_elc;
        next_st.prr = (st.prr & ~prr_clr) | s_proc;

        if (ev.valid) begin
            next_st.res.valid = 1'b1;
            next_st.res.act = enc_act;
            next_st.res.fix = enc_fix;
        end
        if (pgm_take) begin
            next_st.sw.valid = 1'b1;
            next_st.sw.old_a = PGM_OLD;
            next_st.sw.new_a = PGM_NEW;
            next_st.sw.code = {4'h0, enc_code};
            next_st.sw.ilc = enc_ilc;
            next_st.sw.act = enc_act;
        end else if (svc_take) begin
            next_st.sw.valid = 1'b1;
            next_st.sw.old_a = SVC_OLD;
            next_st.sw.new_a = SVC_NEW;
            next_st.sw.code = {4'h0, ev.svc_imm};
            next_st.sw.ilc = ev.via_exec ? ILC_2 : ILC_1;
            next_st.sw.act = ACT_COMPLETE;
        end else if (ext_take) begin
            next_st.sw.valid = 1'b1;
            next_st.sw.old_a = EXT_OLD;
            next_st.sw.new_a = EXT_NEW;
            next_st.sw.code = ext_code;
            next_st.sw.ilc = ev.ilc;
            next_st.sw.act = ev.exit_pt ? ACT_TERMINATE : ACT_COMPLETE;
        end

        // software writes take effect last so a store to the timer wins
        if (wr) begin
            case (paddr)
                OFF_MASK: next_st.msk = pwdata[$bits(mask_type)-1:0];
                OFF_TIMER: next_st.tmr = pwdata;
                OFF_ABNMASK: next_st.acrm = pwdata[N_SRC-1:0];
                OFF_CONFIG: next_st.cfg = pwdata[$bits(cfg_type)-1:0];
                default: next_st.cfg = next_st.cfg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign psw_switch = st.sw;
    assign result = st.res;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence svc_req;
        ev.valid && ev.svc && !enc_take;
    endsequence
    sequence svc_done;
        st.sw.valid && st.sw.old_a == SVC_OLD && st.sw.new_a == SVC_NEW;
    endsequence

    a_pgm_vector: assert property (
        pgm_take |=> st.sw.valid && st.sw.old_a == PGM_OLD && st.sw.new_a == PGM_NEW
    ) else $error("program switch used wrong locations");

    a_svc_switch: assert property (
        svc_req |=> svc_done ##0 (st.sw.code == {4'h0, $past(ev.svc_imm)})
            && (st.sw.ilc == ($past(ev.via_exec) ? ILC_2 : ILC_1))
    ) else $error("supervisor call switch wrong");

    a_dec_ovf_len: assert property (
        pgm_take && enc_code == IC_DCO |=> st.sw.ilc == ILC_3
    ) else $error("decimal overflow length code not 3");

    a_ext_masked: assert property (
        st.sw.valid && st.sw.old_a == EXT_OLD |-> $past(st.msk.sys7) || $past(elc_byp)
    ) else $error("external taken while masked");

    a_ext_vector: assert property (
        ext_take |=> st.sw.new_a == EXT_NEW && st.sw.code == $past(ext_code)
    ) else $error("external switch wrong");

    a_timer_step: assert property (
        tick_e && !hold && !tmr_wr |=> st.tmr == $past(st.tmr) - TMR_DEC
    ) else $error("timer step wrong");

    a_timer_cross: assert property (
        $rose(st.tmr[31]) && !$past(tmr_wr) |-> st.pend[CB_TIMER]
    ) else $error("timer crossing lost");

    a_timer_hold: assert property (
        hold && !tmr_wr |=> $stable(st.tmr)
    ) else $error("timer moved while held");

    a_switch_req: assert property (
        sw_e && sw_ok |=> st.pend[CB_SWITCH]
    ) else $error("panel switch request lost");

    a_prr_keep: assert property (
        prr_clr == '0 |=> (st.prr & $past(st.prr)) == $past(st.prr)
    ) else $error("processor request dropped");

    a_exit_term: assert property (
        ext_take && ev.exit_pt |=> st.sw.act == ACT_TERMINATE
    ) else $error("exit point not terminated");

    a_data_end: assert property (
        ev.valid && ev.cause.data |=> result.valid && result.act == ACT_TERMINATE
    ) else $error("data exception not terminated");

    a_pend_clear: assert property (
        ext_take && !tick_e && !sw_e && sig_e == '0 |=> st.pend == '0
    ) else $error("pending requests not cleared");

    a_elc_state: assert property (
        ext_take && elc_byp && !wr |=> st.cfg.ce_state == ST_THREE
    ) else $error("bypass did not set state Three");

    a_switch_refused: assert property (
        sw_e && !sw_ok && !st.pend[CB_SWITCH] |=> !st.pend[CB_SWITCH]
    ) else $error("panel switch taken while refused");
endmodule : interruption_and_exception_unit

/* rtl/pin_sync.sv */
// three-flop synchroniser whose output moves when the last two agree
module pin_sync #(
    parameter int W = 1
) (
    input logic pclk, // clock
    input logic presetn, // async reset
    input logic [W-1:0] din, // pins from outside
    output logic [W-1:0] dout // settled level
);
    import exc_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_type;
    sync_state_type st;
    sync_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule : pin_sync

/* rtl/prog_exc_encoder.sv */
// picks one program exception and works out how the operation ends
module prog_exc_encoder (
    input exc_pkg::cause_type cause, // raised exceptions
    input exc_pkg::mask_type msk, // program masks
    input logic [1:0] ilc_in, // length of current instruction
    input logic io_instr, // an i/o instruction is running
    input logic ifetch, // storage-stopped hit an instruction fetch
    output logic take, // an interruption is wanted
    output logic [7:0] code, // interruption cause code
    output logic [1:0] ilc, // length code to report
    output exc_pkg::act_type act, // how the operation ends
    output exc_pkg::fix_type fix // floating result fixup
);
    import exc_pkg::*;
    always_comb begin
        take = 1'b1;
        code = '0;
        ilc = ilc_in;
        act = ACT_COMPLETE;
        fix = FIX_NONE;
        if (cause.data) begin
            code = IC_DATA;
            act = ACT_TERMINATE;
        end else if (cause.fxdiv) begin
            code = IC_FXDIV;
            act = ACT_SUPPRESS;
        end else if (cause.dcdiv) begin
            code = IC_DCDIV;
            act = ACT_SUPPRESS;
            ilc = ILC_3;
        end else if (cause.fpdiv) begin
            code = IC_FPDIV;
            act = ACT_SUPPRESS;
        end else if (cause.stop) begin
            code = IC_STOP;
            act = ifetch ? ACT_SUPPRESS : ACT_TERMINATE;
        end else if (cause.lock) begin
            code = IC_LOCK;
            act = io_instr ? ACT_TERMINATE : ACT_COMPLETE;
        end else if (cause.cvb) begin
            code = IC_FXDIV;
        end else if (cause.fxo) begin
            code = IC_FXO;
            take = msk.fxo;
        end else if (cause.dco) begin
            code = IC_DCO;
            take = msk.dco;
            ilc = ILC_3;
        end else if (cause.exo) begin
            code = IC_EXO;
            fix = FIX_DN128;
        end else if (cause.exu) begin
            code = IC_EXU;
            take = msk.exu;
            fix = msk.exu ? FIX_UP128 : FIX_ZERO;
        end else if (cause.sig) begin
            code = IC_SIG;
            take = msk.sig;
            fix = msk.sig ? FIX_NONE : FIX_ZERO;
        end else begin
            take = 1'b0;
        end
    end
endmodule : prog_exc_encoder

/* verif/ext_partner.sv */
// far-side model: mains tick, panel switches and external requesters
module ext_partner (
    input wire logic pclk, // clock
    output logic mains_tick, // mains-derived tick
    output logic panel_sw, // panel interrupt switch
    output logic interlock_sw, // panel interlock switch
    output logic [3:0] ext_sig, // direct-control signals
    output logic [3:0] elc_req, // element_check requests
    output logic [3:0] proc_req // processor requests
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {mains_tick, panel_sw, interlock_sw, ext_sig, elc_req, proc_req} = '0;
    end
    // edge requests stay up long enough to pass the synchroniser
    task automatic pulse(input logic [5:0] sel);
        {ext_sig, panel_sw, mains_tick} <= sel;
        repeat (8) @(posedge pclk);
        {ext_sig, panel_sw, mains_tick} <= '0;
        repeat (8) @(posedge pclk);
    endtask : pulse
    task automatic level(input logic il, input logic [3:0] el, input logic [3:0] pr);
        interlock_sw <= il;
        elc_req <= el;
        proc_req <= pr;
        repeat (6) @(posedge pclk);
    endtask : level
endmodule : ext_partner

/* verif/tb.sv */
// self-checking bench of the interruption and exception unit
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import exc_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, rate_step = 0, stopped = 0, timer_dis_sw = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, t;
    logic pready, pslverr, er, gsw, grs, mains_tick, panel_sw, interlock_sw;
    logic [3:0] ext_sig, elc_req, proc_req;
    logic [7:0] imm;
    pipe_event_type ev = '0;
    switch_type psw_switch, sw;
    result_type result, rs;
    int failures = 0, checks = 0, seed = 31437, h_idle = 0;
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    interruption_and_exception_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ev, .mains_tick, .panel_sw, .interlock_sw,
        .rate_step, .stopped, .timer_dis_sw, .ext_sig, .elc_req, .proc_req, .psw_switch,
        .result);
    ext_partner p (.pclk, .mains_tick, .panel_sw, .interlock_sw, .ext_sig, .elc_req,
        .proc_req);
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic results;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic fire(input pipe_event_type e);
        ev <= e;
        @(posedge pclk);
        ev <= '0;
        gsw = 0;
        grs = 0;
        repeat (3) begin
            @(posedge pclk);
            if (psw_switch.valid === 1'b1) begin
                gsw = 1;
                sw = psw_switch;
            end
            if (result.valid === 1'b1) begin
                grs = 1;
                rs = result;
            end
        end
    endtask : fire
    task automatic ext(input logic x, input logic tk, input logic [11:0] c);
        pipe_event_type e;
        e = '0;
        e.boundary = !x;
        e.exit_pt = x;
        fire(e);
        chk(32'(gsw), 32'(tk), "external taken");
        if (tk) begin
            chk(32'(sw.code), 32'(c), "external code");
            chk(32'({sw.old_a, sw.new_a}), 32'h18058, "external words");
            if (x) begin
                chk(32'(sw.act), 32'(ACT_TERMINATE), "exit point end");
            end
        end
    endtask : ext
    task automatic prog(input logic [11:0] c, input logic [1:0] il, input logic [1:0] iof,
        input logic [7:0] code, input act_type a, input fix_type f, input logic tk);
        pipe_event_type e;
        e = '0;
        e.valid = 1;
        e.cause = c;
        e.ilc = il;
        {e.io_instr, e.ifetch} = iof;
        fire(e);
        chk(32'({grs, rs.act, rs.fix}), 32'({1'b1, a, f}), "program result");
        chk(32'(gsw), 32'(tk), "program taken");
        if (tk) begin
            chk(32'({sw.old_a, sw.new_a}), 32'h28068, "program words");
            chk(32'({sw.ilc, sw.code}), 32'({il, 4'h0, code}), "program code");
        end
    endtask : prog
    initial begin
        pipe_event_type e;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int a = 0; a < 9; a++) begin
            apb(0, 8'(a * 4), '0);
            chk(rd, '0, "reset value");
            chk(32'(er), 32'(a == 8), "slave error");
        end
        apb(1, OFF_MASK, 32'h1F);
        for (int x = 0; x < 2; x++) begin
            imm = 8'($random(seed));
            e = '0;
            e.valid = 1;
            e.svc = 1;
            e.svc_imm = imm;
            e.via_exec = x[0];
            fire(e);
            chk(32'({sw.old_a, sw.new_a}), 32'h20060, "svc words");
            chk(32'({sw.ilc, sw.code}), 32'({2'(x + 1), 4'h0, imm}), "svc code");
        end
        prog(12'h800, ILC_2, 0, IC_DATA, ACT_TERMINATE, FIX_NONE, 1);
        prog(12'h400, ILC_1, 0, IC_FXO, ACT_COMPLETE, FIX_NONE, 1);
        prog(12'h200, ILC_2, 0, IC_FXDIV, ACT_SUPPRESS, FIX_NONE, 1);
        prog(12'h100, ILC_2, 0, IC_FXDIV, ACT_COMPLETE, FIX_NONE, 1);
        prog(12'h080, ILC_3, 0, IC_DCO, ACT_COMPLETE, FIX_NONE, 1);
        prog(12'h040, ILC_3, 0, IC_DCDIV, ACT_SUPPRESS, FIX_NONE, 1);
        prog(12'h020, ILC_1, 0, IC_EXO, ACT_COMPLETE, FIX_DN128, 1);
        prog(12'h010, ILC_2, 0, IC_EXU, ACT_COMPLETE, FIX_UP128, 1);
        prog(12'h008, ILC_1, 0, IC_SIG, ACT_COMPLETE, FIX_NONE, 1);
        prog(12'h004, ILC_2, 0, IC_FPDIV, ACT_SUPPRESS, FIX_NONE, 1);
        prog(12'h002, ILC_1, 2, IC_LOCK, ACT_TERMINATE, FIX_NONE, 1);
        prog(12'h002, ILC_3, 0, IC_LOCK, ACT_COMPLETE, FIX_NONE, 1);
        prog(12'h001, ILC_2, 1, IC_STOP, ACT_SUPPRESS, FIX_NONE, 1);
        prog(12'h001, ILC_1, 0, IC_STOP, ACT_TERMINATE, FIX_NONE, 1);
        apb(1, OFF_MASK, 32'h10);
        prog(12'h400, ILC_1, 0, IC_FXO, ACT_COMPLETE, FIX_NONE, 0);
        prog(12'h080, ILC_3, 0, IC_DCO, ACT_COMPLETE, FIX_NONE, 0);
        prog(12'h010, ILC_1, 0, IC_EXU, ACT_COMPLETE, FIX_ZERO, 0);
        prog(12'h008, ILC_2, 0, IC_SIG, ACT_COMPLETE, FIX_ZERO, 0);
        t = 32'($random(seed)) & 32'h3FF;
        apb(1, OFF_TIMER, t);
        // stopped, instruction step and timer-disable in state Zero each freeze the timer
        for (int h = 0; h < 3; h++) begin
            {timer_dis_sw, rate_step, stopped} <= 3'(1 << h);
            p.level(0, '0, '0);
            p.pulse(6'h01);
            apb(0, OFF_TIMER, '0);
            chk(rd, t, "timer held");
        end
        {timer_dis_sw, rate_step, stopped} <= 3'(h_idle);
        p.level(0, '0, '0);
        p.pulse(6'h01);
        apb(0, OFF_TIMER, '0);
        chk(rd, t - 32'h500, "timer tick");
        ext(0, 1, 12'h080);
        p.pulse(6'h01);
        ext(0, 0, '0);
        for (int s = 0; s < 8; s++) begin
            apb(1, OFF_CONFIG, 32'(s % 4));
            p.level(1'(s / 4), '0, '0);
            p.pulse(6'h02);
            ext(0, s % 4 < 2 || s > 3, 12'h040);
        end
        apb(1, OFF_CONFIG, '0);
        apb(1, OFF_MASK, '0);
        p.pulse(6'h02);
        p.pulse(6'h12);
        ext(0, 0, '0);
        apb(1, OFF_MASK, 32'h10);
        ext(0, 1, 12'h050);
        ext(0, 0, '0);
        p.pulse(6'h04);
        ext(1, 1, 12'h004);
        p.level(0, '0, 4'h1);
        ext(0, 1, 12'h002);
        p.level(0, '0, '0);
        ext(0, 1, 12'h002);
        apb(1, OFF_PROC, 32'hF);
        ext(0, 0, '0);
        apb(1, OFF_MASK, '0);
        apb(1, OFF_CONFIG, 32'h9);
        p.level(0, 4'h1, '0);
        ext(0, 1, 12'h001);
        p.level(0, '0, '0);
        apb(1, OFF_ABN, 32'hF);
        apb(0, OFF_CONFIG, '0);
        chk(rd, 32'hB, "state after bypass");
        results();
    end
endmodule : tb
